// File: ldb_map.svh
// offsets, field positions and reset values of the detection and brightness register
`ifndef LDB_MAP_SVH
`define LDB_MAP_SVH

// register word addresses (word index on the plain port)
`define LDB_ADDR_CFG_LO       4'h0
`define LDB_ADDR_CFG_MID      4'h1
`define LDB_ADDR_CFG_HI       4'h2
`define LDB_ADDR_COMMIT       4'h3
`define LDB_ADDR_STATUS       4'h4

// field positions in the 48-bit word
`define LDB_RED_OPEN_LSB      0
`define LDB_GREEN_OPEN_LSB    2
`define LDB_BLUE_OPEN_LSB     4
`define LDB_RSVD_BIT          6
`define LDB_READBACK_BIT      7
`define LDB_RED_LEVEL_LSB     8
`define LDB_GREEN_LEVEL_LSB   16
`define LDB_BLUE_LEVEL_LSB    24
`define LDB_GLOBAL_LSB        32
`define LDB_REMOVAL_LSB       35
`define LDB_RED_SHORT_LSB     39
`define LDB_GREEN_SHORT_LSB   42
`define LDB_BLUE_SHORT_LSB    45

// first bit of the middle and high half-words
`define LDB_HALF_MID          16
`define LDB_HALF_HI           32

// reset values
`define LDB_OPEN_RST          2'h0
`define LDB_READBACK_RST      1'h0
`define LDB_LEVEL_RST         8'h7f
`define LDB_GLOBAL_RST        3'h3
`define LDB_REMOVAL_RST       4'h7
`define LDB_SHORT_RST         3'h0

// writable bits: all but bit 6
`define LDB_WRITE_MASK        48'hffff_ffff_ffbf

`endif

// File: ldb_pkg.sv
// types of the detection and brightness register
package ldb_pkg;

    typedef struct packed {
        logic [2:0] blue_short_threshold;
        logic [2:0] green_short_threshold;
        logic [2:0] red_short_threshold;
        logic [3:0] short_removal_level;
        logic [2:0] global_brightness_level;
        logic [7:0] blue_color_level;
        logic [7:0] green_color_level;
        logic [7:0] red_color_level;
        logic       detect_readback_enable;
        logic       reserved_zero;
        logic [1:0] blue_open_threshold;
        logic [1:0] green_open_threshold;
        logic [1:0] red_open_threshold;
    } ldb_cfg_t;

endpackage

// File: ldb_regs.sv
// detection threshold and brightness configuration register bank
`timescale 1ns/10ps
`include "ldb_map.svh"

// =========================================================================
// one configuration field: staged copy and live copy
// =========================================================================
module ldb_field
    import ldb_pkg::*;
#(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] rst_val,
    input  wire logic             stage_we,
    input  wire logic [WIDTH-1:0] stage_val,
    input  wire logic             commit,
    output logic      [WIDTH-1:0] stage_q,
    output logic      [WIDTH-1:0] live_q
);

    logic [WIDTH-1:0] stage_r;
    logic [WIDTH-1:0] stage_nxt;
    logic [WIDTH-1:0] live_r;
    logic [WIDTH-1:0] live_nxt;

    // live copy only moves on commit, so all fields land together
    always_comb begin
        stage_nxt = stage_r;
        live_nxt  = live_r;
        if (stage_we) begin
            stage_nxt = stage_val;
        end
        if (commit) begin
            live_nxt = stage_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_r <= rst_val;
            live_r  <= rst_val;
        end else begin
            stage_r <= stage_nxt;
            live_r  <= live_nxt;
        end
    end

    assign stage_q = stage_r;
    assign live_q  = live_r;

endmodule // ldb_field

module ldb_regs
    import ldb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output ldb_cfg_t         CFG,
    output logic             COMMIT_DONE
);

    // =====================================================================
    // state
    // =====================================================================
    wire      [47:0] stage_w;
    wire      [47:0] live_w;
    logic            wr_lo;
    logic            wr_mid;
    logic            wr_hi;
    logic            commit;
    logic     [31:0] rdata_r;
    logic     [31:0] rdata_nxt;
    logic            done_r;
    logic            done_nxt;
    logic     [47:0] rst_word;

    always_comb begin
        rst_word = '0;
        rst_word[`LDB_RED_OPEN_LSB +: 2]    = `LDB_OPEN_RST;
        rst_word[`LDB_GREEN_OPEN_LSB +: 2]  = `LDB_OPEN_RST;
        rst_word[`LDB_BLUE_OPEN_LSB +: 2]   = `LDB_OPEN_RST;
        rst_word[`LDB_READBACK_BIT]         = `LDB_READBACK_RST;
        rst_word[`LDB_RED_LEVEL_LSB +: 8]   = `LDB_LEVEL_RST;
        rst_word[`LDB_GREEN_LEVEL_LSB +: 8] = `LDB_LEVEL_RST;
        rst_word[`LDB_BLUE_LEVEL_LSB +: 8]  = `LDB_LEVEL_RST;
        rst_word[`LDB_GLOBAL_LSB +: 3]      = `LDB_GLOBAL_RST;
        rst_word[`LDB_REMOVAL_LSB +: 4]     = `LDB_REMOVAL_RST;
        rst_word[`LDB_RED_SHORT_LSB +: 3]   = `LDB_SHORT_RST;
        rst_word[`LDB_GREEN_SHORT_LSB +: 3] = `LDB_SHORT_RST;
        rst_word[`LDB_BLUE_SHORT_LSB +: 3]  = `LDB_SHORT_RST;
    end

    // =====================================================================
    // strobe decode
    // =====================================================================
    always_comb begin
        wr_lo  = WR && (ADDR == `LDB_ADDR_CFG_LO);
        wr_mid = WR && (ADDR == `LDB_ADDR_CFG_MID);
        wr_hi  = WR && (ADDR == `LDB_ADDR_CFG_HI);
        // commit needs data bit 0 set
        commit = WR && (ADDR == `LDB_ADDR_COMMIT) && WDATA[0];
    end

    // =====================================================================
    // reserved bit: no storage, always zero
    // =====================================================================
    assign stage_w[`LDB_RSVD_BIT] = 1'b0;
    assign live_w[`LDB_RSVD_BIT]  = 1'b0;

    // =====================================================================
    // field storage
    // =====================================================================
    ldb_field #(.WIDTH(2)) i_red_open (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_RED_OPEN_LSB +: 2]),
        .stage_we (wr_lo),
        .stage_val(WDATA[`LDB_RED_OPEN_LSB +: 2]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_RED_OPEN_LSB +: 2]),
        .live_q   (live_w[`LDB_RED_OPEN_LSB +: 2])
    );

    ldb_field #(.WIDTH(2)) i_green_open (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_GREEN_OPEN_LSB +: 2]),
        .stage_we (wr_lo),
        .stage_val(WDATA[`LDB_GREEN_OPEN_LSB +: 2]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_GREEN_OPEN_LSB +: 2]),
        .live_q   (live_w[`LDB_GREEN_OPEN_LSB +: 2])
    );

    ldb_field #(.WIDTH(2)) i_blue_open (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_BLUE_OPEN_LSB +: 2]),
        .stage_we (wr_lo),
        .stage_val(WDATA[`LDB_BLUE_OPEN_LSB +: 2]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_BLUE_OPEN_LSB +: 2]),
        .live_q   (live_w[`LDB_BLUE_OPEN_LSB +: 2])
    );

    ldb_field #(.WIDTH(1)) i_readback (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_READBACK_BIT]),
        .stage_we (wr_lo),
        .stage_val(WDATA[`LDB_READBACK_BIT]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_READBACK_BIT]),
        .live_q   (live_w[`LDB_READBACK_BIT])
    );

    ldb_field #(.WIDTH(8)) i_red_level (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_RED_LEVEL_LSB +: 8]),
        .stage_we (wr_lo),
        .stage_val(WDATA[`LDB_RED_LEVEL_LSB +: 8]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_RED_LEVEL_LSB +: 8]),
        .live_q   (live_w[`LDB_RED_LEVEL_LSB +: 8])
    );

    ldb_field #(.WIDTH(8)) i_green_level (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_GREEN_LEVEL_LSB +: 8]),
        .stage_we (wr_mid),
        .stage_val(WDATA[(`LDB_GREEN_LEVEL_LSB - `LDB_HALF_MID) +: 8]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_GREEN_LEVEL_LSB +: 8]),
        .live_q   (live_w[`LDB_GREEN_LEVEL_LSB +: 8])
    );

    ldb_field #(.WIDTH(8)) i_blue_level (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_BLUE_LEVEL_LSB +: 8]),
        .stage_we (wr_mid),
        .stage_val(WDATA[(`LDB_BLUE_LEVEL_LSB - `LDB_HALF_MID) +: 8]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_BLUE_LEVEL_LSB +: 8]),
        .live_q   (live_w[`LDB_BLUE_LEVEL_LSB +: 8])
    );

    ldb_field #(.WIDTH(3)) i_global_level (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_GLOBAL_LSB +: 3]),
        .stage_we (wr_hi),
        .stage_val(WDATA[(`LDB_GLOBAL_LSB - `LDB_HALF_HI) +: 3]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_GLOBAL_LSB +: 3]),
        .live_q   (live_w[`LDB_GLOBAL_LSB +: 3])
    );

    ldb_field #(.WIDTH(4)) i_removal (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_REMOVAL_LSB +: 4]),
        .stage_we (wr_hi),
        .stage_val(WDATA[(`LDB_REMOVAL_LSB - `LDB_HALF_HI) +: 4]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_REMOVAL_LSB +: 4]),
        .live_q   (live_w[`LDB_REMOVAL_LSB +: 4])
    );

    ldb_field #(.WIDTH(3)) i_red_short (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_RED_SHORT_LSB +: 3]),
        .stage_we (wr_hi),
        .stage_val(WDATA[(`LDB_RED_SHORT_LSB - `LDB_HALF_HI) +: 3]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_RED_SHORT_LSB +: 3]),
        .live_q   (live_w[`LDB_RED_SHORT_LSB +: 3])
    );

    ldb_field #(.WIDTH(3)) i_green_short (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_GREEN_SHORT_LSB +: 3]),
        .stage_we (wr_hi),
        .stage_val(WDATA[(`LDB_GREEN_SHORT_LSB - `LDB_HALF_HI) +: 3]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_GREEN_SHORT_LSB +: 3]),
        .live_q   (live_w[`LDB_GREEN_SHORT_LSB +: 3])
    );

    ldb_field #(.WIDTH(3)) i_blue_short (
        .clk      (CLK),
        .rst      (SYS_RST),
        .rst_val  (rst_word[`LDB_BLUE_SHORT_LSB +: 3]),
        .stage_we (wr_hi),
        .stage_val(WDATA[(`LDB_BLUE_SHORT_LSB - `LDB_HALF_HI) +: 3]),
        .commit   (commit),
        .stage_q  (stage_w[`LDB_BLUE_SHORT_LSB +: 3]),
        .live_q   (live_w[`LDB_BLUE_SHORT_LSB +: 3])
    );

    // =====================================================================
    // read data and commit pulse
    // =====================================================================
    always_comb begin
        rdata_nxt = '0;
        done_nxt  = commit;
        if (RD) begin
            case (ADDR)
                `LDB_ADDR_CFG_LO: begin
                    rdata_nxt = {16'h0000, live_w[15:0]};
                end
                `LDB_ADDR_CFG_MID: begin
                    rdata_nxt = {16'h0000, live_w[31:16]};
                end
                `LDB_ADDR_CFG_HI: begin
                    rdata_nxt = {16'h0000, live_w[47:32]};
                end
                `LDB_ADDR_STATUS: begin
                    // staging differs from live word
                    rdata_nxt = {31'h0, ((stage_w & `LDB_WRITE_MASK) != live_w)};
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_r <= '0;
            done_r  <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            done_r  <= done_nxt;
        end
    end

    assign RDATA       = rdata_r;
    assign CFG         = ldb_cfg_t'(live_w);
    assign COMMIT_DONE = done_r;

endmodule // ldb_regs

// File: ldb_regs_props.sv
// checks on the detection and brightness register ports
`timescale 1ns/10ps
module ldb_regs_props
    import ldb_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic [3:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire ldb_cfg_t    CFG,
    input wire logic        COMMIT_DONE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire cmt = WR && ADDR == 4'h3 && WDATA[0];
    a_reset_word: assert property (disable iff (1'b0) $fell(SYS_RST) |-> CFG == 48'h003b7f7f7f00)
        else $error("bad reset word");
    a_rsvd_zero: assert property (CFG[6] == 1'b0)
        else $error("bit 6 set");
    a_cfg_holds: assert property (!cmt |=> $stable(CFG))
        else $error("cfg moved");
    a_commit_done: assert property (cmt |=> COMMIT_DONE)
        else $error("no done");
    a_done_cause: assert property (COMMIT_DONE |-> $past(cmt))
        else $error("stray done");
    a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
        else $error("rdata not idle");
    a_read_low: assert property (RD && ADDR == 4'h0 |=> RDATA == {16'h0, $past(CFG[15:0])})
        else $error("low read");
    a_read_mid: assert property (RD && ADDR == 4'h1 |=> RDATA == {16'h0, $past(CFG[31:16])})
        else $error("mid read");
    a_read_high: assert property (RD && ADDR == 4'h2 |=> RDATA == {16'h0, $past(CFG[47:32])})
        else $error("high read");
endmodule // ldb_regs_props

// File: tb.sv
// self-checking bench of the detection and brightness register
`timescale 1ns/10ps
module tb;
    import ldb_pkg::*;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [3:0]  ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [31:0] RDATA;
    ldb_cfg_t    CFG;
    logic        COMMIT_DONE;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #5 CLK = ~CLK;
    ldb_regs i_ldb_regs (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .CFG(CFG), .COMMIT_DONE(COMMIT_DONE));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 check({16'h0, RDATA}, {16'h0, exp});
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 500) begin
            n_mismatch++;
            complete_run;
        end
    end
    initial begin
        repeat (3) @(posedge CLK);
        SYS_RST <= 1'b0;
        #1 check(CFG, 48'h003b7f7f7f00);
        rd(4'h1, 32'h7f7f);
        wr(4'h0, 32'hffffffff);
        wr(4'h1, 32'h1234a55a);
        wr(4'h2, 32'h0000ffff);
        wr(4'h3, 32'h0);
        #1 check(48'(COMMIT_DONE), 48'h0);
        rd(4'h0, 32'h7f00);
        rd(4'h4, 32'h1);
        wr(4'h9, 32'hffff);
        rd(4'h9, 32'h0);
        wr(4'h3, 32'h1);
        #1 check(CFG, 48'hffffa55affbf);
        rd(4'h0, 32'hffbf);
        rd(4'h2, 32'hffff);
        wr(4'h0, 32'h0040);
        wr(4'h1, 32'h0);
        wr(4'h2, 32'h0);
        wr(4'h3, 32'h1);
        #1 check(CFG, 48'h0);
        wr(4'h0, 32'h12f9);
        wr(4'h1, 32'h3456);
        wr(4'h2, 32'h8755);
        wr(4'h3, 32'h1);
        #1 check(CFG, 48'h8755345612b9);
        check(48'(COMMIT_DONE), 48'h1);
        check(48'(CFG.red_open_threshold), 48'h1);
        check(48'(CFG.green_open_threshold), 48'h2);
        check(48'(CFG.blue_open_threshold), 48'h3);
        check(48'(CFG.detect_readback_enable), 48'h1);
        check(48'(CFG.red_color_level), 48'h12);
        check(48'(CFG.green_color_level), 48'h56);
        check(48'(CFG.blue_color_level), 48'h34);
        check(48'(CFG.global_brightness_level), 48'h5);
        check(48'(CFG.short_removal_level), 48'ha);
        check(48'(CFG.red_short_threshold), 48'h6);
        check(48'(CFG.green_short_threshold), 48'h1);
        check(48'(CFG.blue_short_threshold), 48'h4);
        rd(4'h1, 32'h3456);
        complete_run;
    end
endmodule // tb
bind ldb_regs ldb_regs_props i_ldb_regs_props (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CFG(CFG), .COMMIT_DONE(COMMIT_DONE));
